// ### design/dca_pkg.sv
// What this block does
// (R1) Barrier drains the write buffer so all pending dirty data reaches memory.
// (R2) Barrier completes only after every outstanding read transfer has finished.
// (R3) Tag and data arrays are reachable by program and debug accesses.
// (R4) Window base is a parameter inside an unmapped privileged segment.
// (R5) Window spans twice cache capacity: half tags, half data.
// (R6) Instruction fetches and peripheral or DMA masters get no window access.
// (R7) Window enabled only when the upper base field matches the window base.
// (R8) Select bit below base: one picks tag array, zero picks data array.
// (R9) Two-bit way field picks one of four lines in the set.
// (R10) Low five bits pick the byte; set index field sits above them.
// (R11) Data accesses naturally aligned; tag accesses aligned words only.
// (R12) Tag word 0: valid bit 0, lock bit 1, line address upper bits.
// (R13) Tag word 1: eight dirty flags, bit zero for lowest word.
// (R14) Tag word 2 reads zero and ignores writes.
// (R15) Tag word 3: six replacement bits shared by the set.
// (R16) Replacement fields hold first, second, third most recent ways.
// (R17) Software must not repeat a way index among recency fields.
// (R18) Tag words alias modulo four across the line span.
// (R19) Reset marks every cache line invalid.
// (R20) Window access touches one entry; no lookup, no bus transfer.
package dca_pkg;
    localparam int SET_W = 6;
    localparam int WAY_W = 2;
    localparam int BYTE_W = 5;
    localparam int WORD_W = 3;
    localparam int LINE_WORDS = 8;
    localparam int BASE_FIELD_W_DOC = 26 - SET_W;
    localparam int SET_LSB = BYTE_W;
    localparam int WAY_LSB = SET_LSB + SET_W;
    localparam int TD_BIT = WAY_LSB + WAY_W;
    localparam int BASE_LSB = TD_BIT + 1;
    localparam int BASE_W = 32 - BASE_LSB;
    localparam int LADDR_W = 27 - SET_W;
    localparam int LADDR_LSB = 32 - LADDR_W;
    localparam int REPL_W = 6;
    localparam int ENTRIES = 1 << (SET_W + WAY_W);
    localparam int DATA_WORDS = ENTRIES * LINE_WORDS;
    localparam logic [BASE_W-1:0] WIN_BASE = 18'h2_ffff;
    localparam logic [1:0] SRC_DATA = 2'h0;
    localparam logic [1:0] SRC_DEBUG = 2'h1;
    localparam logic [1:0] SRC_IFETCH = 2'h2;
    localparam logic [1:0] SRC_DMA = 2'h3;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] TWORD_ADDR = 2'h0;
    localparam logic [1:0] TWORD_DIRTY = 2'h1;
    localparam logic [1:0] TWORD_EMPTY = 2'h2;
    localparam logic [1:0] TWORD_REPL = 2'h3;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DRAIN = 3'b010,
        ST_DONE = 3'b100
    } dca_sync_state_type;
endpackage

// ### design/dca_arr_if.sv
`timescale 1ns/1ns
interface dca_arr_if;
    logic en;
    logic we;
    logic tag_sel;
    logic [3:0] be;
    logic [1:0] way;
    logic [5:0] set;
    logic [2:0] word;
    logic [31:0] wdata;
    logic [31:0] data_rdata;
    logic [31:0] tag_rdata;
    modport ctrl (output en, we, tag_sel, be, way, set, word, wdata, input data_rdata, tag_rdata);
    modport data_side (input en, we, tag_sel, be, way, set, word, wdata, output data_rdata);
    modport tag_side (input en, we, tag_sel, be, way, set, word, wdata, output tag_rdata);
endinterface

// ### design/dca_data_ram.sv
`timescale 1ns/1ns
module dca_data_ram (
    input wire logic mclk,
    input wire logic rst_sync_n,
    dca_arr_if.data_side arr
);
    logic [31:0] mem [0:dca_pkg::DATA_WORDS-1];
    logic [10:0] idx;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic sel;
    logic [31:0] wword;

    always_comb
    begin
        idx = {arr.way, arr.set, arr.word};
        sel = arr.en && !arr.tag_sel;
        rdata_d = (sel && !arr.we) ? mem[idx] : rdata_q;
    end

    // Byte lanes merged into the addressed word, one write port
    for (genvar b = 0; b < 4; b++)
    begin : g_lane
        assign wword[8*b +: 8] = arr.be[b] ? arr.wdata[8*b +: 8] : mem[idx][8*b +: 8];
    end

    always_ff @(posedge mclk)
    begin
        if (sel && arr.we)
            mem[idx] <= wword; // R20
    end

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            rdata_q <= dca_pkg::RDATA_RESET;
        else
            rdata_q <= rdata_d;
    end

    assign arr.data_rdata = rdata_q;
endmodule

// ### design/dca_tag_store.sv
`timescale 1ns/1ns
module dca_tag_store (
    input wire logic mclk,
    input wire logic rst_sync_n,
    dca_arr_if.tag_side arr
);
    logic [dca_pkg::ENTRIES-1:0] valid_q;
    logic [dca_pkg::ENTRIES-1:0] valid_d;
    logic [dca_pkg::ENTRIES-1:0] lock_q;
    logic [dca_pkg::ENTRIES-1:0] lock_d;
    logic [dca_pkg::LADDR_W-1:0] laddr_mem [0:dca_pkg::ENTRIES-1];
    logic [dca_pkg::LINE_WORDS-1:0] dirty_mem [0:dca_pkg::ENTRIES-1];
    logic [dca_pkg::REPL_W-1:0] repl_mem [0:(1 << dca_pkg::SET_W)-1];
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0] idx;
    logic [1:0] tword;
    logic rd;
    logic wr;

    always_comb
    begin
        idx = {arr.way, arr.set};
        tword = arr.word[1:0]; // R18
        rd = arr.en && arr.tag_sel && !arr.we;
        wr = arr.en && arr.tag_sel && arr.we;
        valid_d = valid_q;
        lock_d = lock_q;
        if (wr && tword == dca_pkg::TWORD_ADDR)
        begin
            valid_d[idx] = arr.wdata[0]; // R12
            lock_d[idx] = arr.wdata[1]; // R12
        end
        rdata_d = rdata_q;
        if (rd)
        begin
            unique case (tword)
                dca_pkg::TWORD_ADDR:
                    rdata_d = {laddr_mem[idx], 9'h000, lock_q[idx], valid_q[idx]}; // R12
                dca_pkg::TWORD_DIRTY:
                    rdata_d = {24'h00_0000, dirty_mem[idx]}; // R13
                dca_pkg::TWORD_EMPTY:
                    rdata_d = 32'h0000_0000; // R14
                dca_pkg::TWORD_REPL:
                    rdata_d = {26'h000_0000, repl_mem[arr.set]}; // R15 R16
            endcase
        end
    end

    // Other tag fields are plain storage, no reset needed
    always_ff @(posedge mclk)
    begin
        if (wr && tword == dca_pkg::TWORD_ADDR)
            laddr_mem[idx] <= arr.wdata[31:dca_pkg::LADDR_LSB]; // R12
        if (wr && tword == dca_pkg::TWORD_DIRTY)
            dirty_mem[idx] <= arr.wdata[7:0]; // R13
        if (wr && tword == dca_pkg::TWORD_REPL)
            repl_mem[arr.set] <= arr.wdata[5:0]; // R15
    end

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            valid_q <= '0; // R19
            lock_q <= '0;
            rdata_q <= dca_pkg::RDATA_RESET;
        end
        else
        begin
            valid_q <= valid_d;
            lock_q <= lock_d;
            rdata_q <= rdata_d;
        end
    end

    assign arr.tag_rdata = rdata_q;
endmodule

// ### design/dca_top.sv
`timescale 1ns/1ns
module dca_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_source,
    input wire logic req_priv,
    input wire logic [1:0] req_size,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic rsp_valid_q,
    output logic rsp_err_q,
    output logic [31:0] rsp_rdata_q,
    input wire logic sync_req,
    input wire logic wbuf_empty,
    input wire logic rd_pending,
    output logic wbuf_flush_q,
    output logic sync_busy_q,
    output logic sync_done_q
);
    logic rst_q1;
    logic rst_q2;
    logic rst_sync_n;
    logic in_win;
    logic src_ok;
    logic priv_ok;
    logic align_ok;
    logic is_tag;
    logic claim;
    logic [3:0] be;
    logic s1_valid_q;
    logic s1_valid_d;
    logic s1_err_q;
    logic s1_err_d;
    logic s1_tag_q;
    logic s1_tag_d;
    logic s1_write_q;
    logic s1_write_d;
    logic rsp_valid_d;
    logic rsp_err_d;
    logic [31:0] rsp_rdata_d;
    dca_pkg::dca_sync_state_type state_q;
    dca_pkg::dca_sync_state_type state_d;
    logic wbuf_flush_d;
    logic sync_busy_d;
    logic sync_done_d;

    dca_arr_if arr ();

    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end
    assign rst_sync_n = rst_q2;

    // Window decode
    always_comb
    begin
        in_win = req_addr[31:dca_pkg::BASE_LSB] == dca_pkg::WIN_BASE; // R7 R5
        src_ok = req_source == dca_pkg::SRC_DATA || req_source == dca_pkg::SRC_DEBUG; // R6 R3
        priv_ok = req_priv || req_source == dca_pkg::SRC_DEBUG; // R4
        is_tag = req_addr[dca_pkg::TD_BIT]; // R8
        unique case (req_size)
            dca_pkg::SIZE_BYTE: align_ok = !is_tag;
            dca_pkg::SIZE_HALF: align_ok = !is_tag && !req_addr[0];
            dca_pkg::SIZE_WORD: align_ok = req_addr[1:0] == 2'h0; // R11
            default: align_ok = 1'b0;
        endcase
        claim = req_valid && in_win && src_ok && priv_ok && align_ok;
        unique case (req_size)
            dca_pkg::SIZE_BYTE: be = 4'b0001 << req_addr[1:0];
            dca_pkg::SIZE_HALF: be = req_addr[1] ? 4'b1100 : 4'b0011;
            default: be = 4'b1111;
        endcase
    end

    // Array port: only the addressed entry is touched
    always_comb
    begin
        arr.en = claim; // R20
        arr.we = req_write;
        arr.tag_sel = is_tag; // R8
        arr.be = be;
        arr.way = req_addr[dca_pkg::WAY_LSB +: dca_pkg::WAY_W]; // R9
        arr.set = req_addr[dca_pkg::SET_LSB +: dca_pkg::SET_W]; // R10
        arr.word = req_addr[4:2]; // R10
        arr.wdata = req_wdata;
    end

    dca_data_ram u_data (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .arr(arr)
    );

    dca_tag_store u_tag (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .arr(arr)
    );

    // Response pipeline
    always_comb
    begin
        s1_valid_d = req_valid;
        s1_err_d = req_valid && !claim; // R6 R7
        s1_tag_d = is_tag;
        s1_write_d = req_write;
        rsp_valid_d = s1_valid_q;
        rsp_err_d = s1_valid_q && s1_err_q;
        rsp_rdata_d = 32'h0000_0000;
        if (s1_valid_q && !s1_err_q && !s1_write_q)
            rsp_rdata_d = s1_tag_q ? arr.tag_rdata : arr.data_rdata; // R3
    end

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            s1_valid_q <= 1'b0;
            s1_err_q <= 1'b0;
            s1_tag_q <= 1'b0;
            s1_write_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_err_q <= 1'b0;
            rsp_rdata_q <= dca_pkg::RDATA_RESET;
        end
        else
        begin
            s1_valid_q <= s1_valid_d;
            s1_err_q <= s1_err_d;
            s1_tag_q <= s1_tag_d;
            s1_write_q <= s1_write_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_err_q <= rsp_err_d;
            rsp_rdata_q <= rsp_rdata_d;
        end
    end

    // Barrier sequencer
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            dca_pkg::ST_IDLE:
                if (sync_req)
                    state_d = dca_pkg::ST_DRAIN;
            dca_pkg::ST_DRAIN:
                if (wbuf_empty && !rd_pending)
                    state_d = dca_pkg::ST_DONE; // R2
            dca_pkg::ST_DONE:
                state_d = dca_pkg::ST_IDLE;
            default:
                state_d = dca_pkg::ST_IDLE;
        endcase
        wbuf_flush_d = state_d == dca_pkg::ST_DRAIN && !wbuf_empty; // R1
        sync_busy_d = state_d == dca_pkg::ST_DRAIN;
        sync_done_d = state_d == dca_pkg::ST_DONE; // R2
    end

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_q <= dca_pkg::ST_IDLE;
            wbuf_flush_q <= 1'b0;
            sync_busy_q <= 1'b0;
            sync_done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            wbuf_flush_q <= wbuf_flush_d;
            sync_busy_q <= sync_busy_d;
            sync_done_q <= sync_done_d;
        end
    end

    // Helpers for checks
    logic tag_written_q;
    logic tag_rd_w0;
    logic tag_rd_w1;
    logic tag_rd_w2;
    logic tag_rd_w3;
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            tag_written_q <= 1'b0;
        else if (claim && is_tag && req_write)
            tag_written_q <= 1'b1;
    end
    always_comb
    begin
        tag_rd_w0 = claim && is_tag && !req_write && req_addr[3:2] == dca_pkg::TWORD_ADDR;
        tag_rd_w1 = claim && is_tag && !req_write && req_addr[3:2] == dca_pkg::TWORD_DIRTY;
        tag_rd_w2 = claim && is_tag && !req_write && req_addr[3:2] == dca_pkg::TWORD_EMPTY;
        tag_rd_w3 = claim && is_tag && !req_write && req_addr[3:2] == dca_pkg::TWORD_REPL;
    end

    // Shadow of the last data word written, for read-back checks
    logic shadow_ok_q;
    logic shadow_ok_d;
    logic [31:0] shadow_addr_q;
    logic [31:0] shadow_addr_d;
    logic [31:0] shadow_data_q;
    logic [31:0] shadow_data_d;
    logic [31:0] shadow_merge;
    logic shadow_hit;
    for (genvar b = 0; b < 4; b++)
    begin : g_shadow
        assign shadow_merge[8*b +: 8] = be[b] ? req_wdata[8*b +: 8] : shadow_data_q[8*b +: 8];
    end
    always_comb
    begin
        shadow_hit = shadow_ok_q && shadow_addr_q == {req_addr[31:2], 2'h0};
        shadow_ok_d = shadow_ok_q;
        shadow_addr_d = shadow_addr_q;
        shadow_data_d = shadow_data_q;
        if (claim && !is_tag && req_write)
        begin
            shadow_ok_d = shadow_hit || be == 4'hf;
            shadow_addr_d = {req_addr[31:2], 2'h0};
            shadow_data_d = shadow_merge;
        end
    end
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            shadow_ok_q <= 1'b0;
            shadow_addr_q <= 32'h0000_0000;
            shadow_data_q <= 32'h0000_0000;
        end
        else
        begin
            shadow_ok_q <= shadow_ok_d;
            shadow_addr_q <= shadow_addr_d;
            shadow_data_q <= shadow_data_d;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_sync_n);

    a_base_segment: assert property (dca_pkg::WIN_BASE[17:15] inside {3'b100, 3'b101}) // R4
        else $error("window base outside privileged unmapped segment");
    a_base_mismatch: assert property (req_valid && !in_win |-> ##2 rsp_valid_q && rsp_err_q) // R7
        else $error("access outside window was not refused");
    a_fetch_refused: assert property (req_valid && !src_ok |-> ##2 rsp_err_q) // R6
        else $error("fetch or dma master reached the window");
    a_tag_size: assert property (req_valid && is_tag && req_size != dca_pkg::SIZE_WORD // R11
        |-> ##2 rsp_err_q)
        else $error("non-word tag access accepted");
    a_claim_answer: assert property (claim |-> ##2 rsp_valid_q && !rsp_err_q) // R3
        else $error("claimed access not answered in two cycles");
    a_word0_zero: assert property (tag_rd_w0 |-> ##2 rsp_rdata_q[10:2] == 9'h000) // R12
        else $error("tag word 0 unused bits not zero");
    a_word1_zero: assert property (tag_rd_w1 |-> ##2 rsp_rdata_q[31:8] == 24'h00_0000) // R13
        else $error("tag word 1 upper bits not zero");
    a_word2_empty: assert property (tag_rd_w2 |-> ##2 rsp_rdata_q == 32'h0000_0000) // R14
        else $error("tag word 2 not zero");
    a_word3_zero: assert property (tag_rd_w3 |-> ##2 rsp_rdata_q[31:6] == 26'h000_0000) // R15
        else $error("tag word 3 upper bits not zero");
    a_reset_invalid: assert property (tag_rd_w0 && !tag_written_q |-> ##2 !rsp_rdata_q[0]) // R19
        else $error("line valid after reset without tag write");
    a_sync_drain: assert property (sync_busy_q && !wbuf_empty |-> wbuf_flush_q) // R1
        else $error("barrier not draining write buffer");
    a_sync_wait: assert property (sync_done_q |-> $past(wbuf_empty) && !$past(rd_pending)) // R2
        else $error("barrier completed with reads outstanding");
    a_sync_bound: assert property ($rose(sync_busy_q) && wbuf_empty && !rd_pending // R2
        |-> ##1 sync_done_q)
        else $error("idle barrier did not finish in one cycle");
    a_data_readback: assert property (claim && !is_tag && !req_write && shadow_hit // R20
        |-> ##2 rsp_rdata_q == $past(shadow_data_q, 2))
        else $error("data word read back differs from last write");
    a_unpriv_refused: assert property (req_valid && req_source == dca_pkg::SRC_DATA // R4
        && !req_priv |-> ##2 rsp_err_q)
        else $error("unprivileged data access reached the window");
    a_half_odd: assert property (req_valid && req_size == dca_pkg::SIZE_HALF // R11
        && req_addr[0] |-> ##2 rsp_err_q)
        else $error("odd half-word access accepted");
    a_write_quiet: assert property (req_valid && req_write // R3
        |-> ##2 rsp_rdata_q == 32'h0000_0000)
        else $error("write answered with read data");
    a_err_quiet: assert property (req_valid && !claim // R6
        |-> ##2 rsp_rdata_q == 32'h0000_0000)
        else $error("refused access answered with data");
    a_done_pulse: assert property (sync_done_q |=> !sync_done_q && !sync_busy_q) // R2
        else $error("barrier done not a single pulse");
    a_sync_start: assert property (sync_req && state_q == dca_pkg::ST_IDLE |=> sync_busy_q) // R1
        else $error("barrier request not taken");

    c_sync_done: cover property (sync_busy_q ##[1:20] sync_done_q);
    c_tag_read: cover property (tag_rd_w3 ##2 rsp_valid_q);
    c_data_write: cover property (claim && !is_tag && req_write);
    c_refused: cover property (rsp_err_q);
    c_sync_reads: cover property (sync_busy_q && wbuf_empty && rd_pending);
endmodule

// ### bench/dca_far_model.sv
`timescale 1ns/1ns
module dca_far_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push_wr,
    input wire logic push_rd,
    output logic wbuf_empty,
    output logic rd_pending
);
    logic [3:0] wcnt_q;
    logic [4:0] rtim_q;
    logic [1:0] pace_q;
    // Slow buffer: one entry leaves every fourth clock cycle while flushing
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wcnt_q <= 4'h0;
            rtim_q <= 5'h00;
            pace_q <= 2'h0;
        end
        else
        begin
            pace_q <= pace_q + 2'h1;
            if (push_wr)
                wcnt_q <= wcnt_q + 4'h1;
            else if (flush && pace_q == 2'h3 && wcnt_q != 4'h0)
                wcnt_q <= wcnt_q - 4'h1;
            if (push_rd)
                rtim_q <= 5'h14;
            else if (rtim_q != 5'h00)
                rtim_q <= rtim_q - 5'h01;
        end
    end
    assign wbuf_empty = (wcnt_q == 4'h0);
    assign rd_pending = (rtim_q != 5'h00);
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic mclk = 0;
    logic rst_n = 0;
    logic req_valid = 0;
    logic req_write = 0;
    logic [1:0] req_source = 2'h0;
    logic req_priv = 1;
    logic [1:0] req_size = 2'h2;
    logic [31:0] req_addr = 32'h0000_0000;
    logic [31:0] req_wdata = 32'h0000_0000;
    logic sync_req = 0;
    logic push_wr = 0;
    logic push_rd = 0;
    logic rsp_valid_q, rsp_err_q, wbuf_flush_q, sync_busy_q, sync_done_q;
    logic wbuf_empty, rd_pending;
    logic [31:0] rsp_rdata_q;
    logic r_err;
    logic [31:0] r_data;
    int n_errors = 0;
    int checks_done = 0;
    integer seed;
    always #25 mclk = ~mclk;
    dca_top dut_u (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
        .req_source(req_source), .req_priv(req_priv), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid_q(rsp_valid_q),
        .rsp_err_q(rsp_err_q), .rsp_rdata_q(rsp_rdata_q), .sync_req(sync_req),
        .wbuf_empty(wbuf_empty), .rd_pending(rd_pending), .wbuf_flush_q(wbuf_flush_q),
        .sync_busy_q(sync_busy_q), .sync_done_q(sync_done_q));
    dca_far_model far_u (.mclk(mclk), .rst_n(rst_n), .flush(wbuf_flush_q),
        .push_wr(push_wr), .push_rd(push_rd), .wbuf_empty(wbuf_empty),
        .rd_pending(rd_pending));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp, input string what);
        chk({31'h0, got}, {31'h0, exp}, what);
    endtask
    function automatic logic [31:0] wa(input logic t, input logic [1:0] w,
        input logic [5:0] s, input logic [4:0] b);
        return {dca_pkg::WIN_BASE, t, w, s, b};
    endfunction
    function automatic logic [31:0] lane_mask(input logic [1:0] sz, input logic [1:0] off);
        if (sz == dca_pkg::SIZE_BYTE)
            return 32'h0000_00ff << (8 * off);
        if (sz == dca_pkg::SIZE_HALF)
            return 32'h0000_ffff << (8 * off);
        return 32'hffff_ffff;
    endfunction
    task automatic acc(input logic w, input logic [1:0] src, input logic pv,
        input logic [1:0] sz, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(negedge mclk);
        req_valid = 1;
        req_write = w;
        req_source = src;
        req_priv = pv;
        req_size = sz;
        req_addr = a;
        req_wdata = wd;
        @(negedge mclk);
        req_valid = 0;
        while (rsp_valid_q !== 1'b1 && n < 4)
        begin
            @(negedge mclk);
            n++;
        end
        chk(n, 1, "answer latency");
        r_err = (n < 4) ? rsp_err_q : 1'bx;
        r_data = rsp_rdata_q;
    endtask
    task automatic pulse_sync(input int lim, output logic ok);
        int n;
        n = 0;
        @(negedge mclk);
        sync_req = 1;
        @(negedge mclk);
        sync_req = 0;
        chk_flag(sync_busy_q, 1, "barrier busy");
        while (sync_done_q !== 1'b1 && n < lim)
        begin
            @(negedge mclk);
            n++;
        end
        chk_flag(sync_busy_q, 0, "busy ends with done");
        ok = (n < lim) && wbuf_empty && !rd_pending;
    endtask
    initial
    begin
        #(50 * 20000);
        n_errors++;
        report_and_stop;
    end
    initial
    begin
        logic [1:0] w;
        logic [5:0] s;
        logic [2:0] wd;
        logic [1:0] sz;
        logic [1:0] off;
        logic [31:0] v;
        logic [31:0] exp;
        logic [31:0] a;
        logic ok;
        logic seen;
        seed = 32'hf90b5a1c;
        repeat (8) @(negedge mclk);
        rst_n = 1;
        repeat (3) @(negedge mclk);
        for (int i = 0; i < 8; i++)
        begin
            acc(0, dca_pkg::SRC_DEBUG, 0, 2'h2, wa(1, i[1:0], 6'($random(seed)), 5'h00), 0);
            chk(r_data & 32'h0000_0003, 32'h0000_0000, "flags after reset");
        end
        $display("test reset done");
        for (int i = 0; i < 24; i++)
        begin
            {w, s, wd, sz, off} = 15'($random(seed));
            sz = (sz == 2'h3) ? 2'h2 : sz;
            off = (sz == 2'h1) ? {off[1], 1'b0} : ((sz == 2'h2) ? 2'h0 : off);
            exp = $random(seed);
            acc(1, dca_pkg::SRC_DATA, 1, 2'h2, wa(0, w, s, {wd, 2'h0}), exp);
            v = $random(seed);
            acc(1, dca_pkg::SRC_DEBUG, 0, sz, wa(0, w, s, {wd, off}), v);
            exp = (exp & ~lane_mask(sz, off)) | (v & lane_mask(sz, off));
            acc(0, i[0], 1, 2'h2, wa(0, w, s, {wd, 2'h0}), 0);
            chk(r_data, exp, "data word");
            chk_flag(r_err, 0, "data err");
        end
        $display("test data done");
        for (int i = 0; i < 6; i++)
        begin
            {w, s} = 8'($random(seed));
            v = $random(seed);
            acc(1, dca_pkg::SRC_DATA, 1, 2'h2, wa(1, w, s, 5'h00), v);
            acc(0, dca_pkg::SRC_DATA, 1, 2'h2, wa(1, w, s, 5'h10), 0);
            chk(r_data, v & 32'hffff_f803, "tag addr word");
            acc(1, dca_pkg::SRC_DEBUG, 1, 2'h2, wa(1, w, s, 5'h04), v);
            acc(0, dca_pkg::SRC_DEBUG, 1, 2'h2, wa(1, w, s, 5'h04), 0);
            chk(r_data, v & 32'h0000_00ff, "tag dirty word");
            acc(1, dca_pkg::SRC_DATA, 1, 2'h2, wa(1, w, s, 5'h08), v);
            acc(0, dca_pkg::SRC_DATA, 1, 2'h2, wa(1, w, s, 5'h18), 0);
            chk(r_data, 32'h0000_0000, "tag empty word");
            v = {v[31:6], w, w + 2'h1, w + 2'h2};
            acc(1, dca_pkg::SRC_DATA, 1, 2'h2, wa(1, w, s, 5'h0c), v);
            acc(0, dca_pkg::SRC_DATA, 1, 2'h2, wa(1, w + 2'h3, s, 5'h1c), 0);
            chk(r_data, v & 32'h0000_003f, "tag replace word");
        end
        $display("test tags done");
        a = wa(0, 2'h1, 6'h03, 5'h00);
        acc(1, dca_pkg::SRC_DATA, 1, 2'h2, a, 32'h1234_5678);
        for (int i = 0; i < 8; i++)
        begin
            case (i)
                0: acc(1, 0, 1, 2'h2, a ^ 32'h0001_0000, 0);
                1: acc(1, dca_pkg::SRC_IFETCH, 1, 2'h2, a, 0);
                2: acc(0, dca_pkg::SRC_DMA, 1, 2'h2, a, 0);
                3: acc(1, dca_pkg::SRC_DATA, 0, 2'h2, a, 0);
                4: acc(1, 0, 1, 2'h1, a + 1, 0);
                5: acc(1, 0, 1, 2'h2, a + 2, 0);
                6: acc(1, 0, 1, 2'h0, a | 32'h0000_2000, 0);
                default: acc(1, 0, 1, 2'h3, a, 0);
            endcase
            chk_flag(r_err, 1, "refusal flag");
            chk(r_data, 0, "refusal data");
        end
        acc(0, dca_pkg::SRC_DATA, 1, 2'h2, a, 0);
        chk(r_data, 32'h1234_5678, "word after refusals");
        chk_flag(wbuf_flush_q, 0, "no bus traffic");
        $display("test refusals done");
        pulse_sync(6, ok);
        chk_flag(ok, 1, "idle barrier");
        repeat (3)
        begin
            @(negedge mclk);
            push_wr = 1;
            @(negedge mclk);
            push_wr = 0;
        end
        push_rd = 1;
        @(negedge mclk);
        push_rd = 0;
        seen = 0;
        fork
            pulse_sync(300, ok);
            repeat (4)
            begin
                @(negedge mclk);
                seen = seen | wbuf_flush_q;
            end
        join
        chk_flag(seen, 1, "flush during barrier");
        chk_flag(ok, 1, "barrier waits for drain");
        $display("test barrier done");
        report_and_stop;
    end
endmodule
